//--- core/aie_core.sv
// accumulator instruction executor
`timescale 1ns/1ps
`default_nettype none
module aie_core #(
    parameter int STACK_DEPTH = aie_pkg::AIE_DEPTH
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // program memory
    input  wire logic [13:0] instr,
    input  wire logic        instr_valid,
    output logic [12:0]      pc,
    // data register file
    output logic [6:0]       reg_addr,
    input  wire logic [7:0]  reg_rdata,
    output logic             reg_we,
    output logic [7:0]       reg_wdata,
    // latch and call link
    input  wire logic [4:0]  program_counter_high_latch,
    input  wire logic        call_push,
    input  wire logic [12:0] call_addr,
    // direction registers
    output logic             dir_we,
    output logic [2:0]       dir_sel,
    output logic [7:0]       dir_wdata,
    // state
    output logic [7:0]       acc,
    output logic             zero_flag,
    output logic             carry_flag,
    output logic             digit_carry_flag,
    output logic             global_interrupt_enable,
    input  wire logic        int_enable_clear,
    output logic             unhandled
);
    import aie_pkg::*;
    if (STACK_DEPTH < 2) begin : g_bad_depth
        $error("aie_core: stack too shallow");
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    aie_stack_if sif ();
    aie_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clk   (clk),
        .reset (reset),
        .st    (sif)
    );

    aie_state_t state_r;
    logic       exec;
    logic [3:0] opc;
    logic       dbit;
    logic [7:0] lit;
    logic       is_reg;
    logic       is_add_lit, is_and_lit, is_xor_lit, is_ret_lit;
    logic       is_branch, is_ret, is_reti, is_dir;
    logic       is_add_reg, is_and_reg, is_xor_reg;
    logic       is_inc, is_decsz, is_swap;

    assign exec = instr_valid && state_r == AIE_RUN;
    assign opc  = instr[11:8];
    assign dbit = instr[7];
    assign lit  = instr[7:0];
    assign reg_addr = instr[6:0]; // RULE_04
    assign is_reg = instr[13:12] == 2'b00;
    assign is_add_lit = instr[13:9] == 5'h1f;            // RULE_01
    assign is_and_lit = instr[13:12] == 2'b11 && opc == LIT_AND_C;
    assign is_xor_lit = instr[13:12] == 2'b11 && opc == LIT_XOR_C;
    assign is_ret_lit = instr[13:10] == 4'hd;            // RULE_10
    assign is_branch  = instr[13:11] == 3'h5;            // RULE_07
    assign is_ret     = instr == AIE_RET_W;              // RULE_11
    assign is_reti    = instr == AIE_RETI_W;             // RULE_09
    assign is_dir     = instr[13:3] == AIE_DIR_HI &&
                        instr[2:0] >= AIE_DIR_LO &&
                        instr[2:0] <= AIE_DIR_HI_SEL;    // RULE_13
    assign is_add_reg = is_reg && opc == OP_ADD_REG_C;
    assign is_and_reg = is_reg && opc == OP_AND_REG_C;
    assign is_xor_reg = is_reg && opc == OP_XOR_REG_C;
    assign is_inc     = is_reg && opc == OP_INC_C;
    assign is_decsz   = is_reg && opc == OP_DECSZ_C;
    assign is_swap    = is_reg && opc == OP_SWAP_C;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] res;
    logic [7:0] opnd;
    logic       to_reg;
    logic       upd_z, upd_c;
    logic       known;

    always_comb begin
        opnd    = is_reg ? reg_rdata : lit;
        sum     = {1'b0, acc} + {1'b0, opnd};
        low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]}; // RULE_16
        res     = sum[7:0];
        upd_z   = 1'b0;
        upd_c   = 1'b0;
        known   = 1'b1;
        if (is_add_lit || is_add_reg) begin             // RULE_01 RULE_03
            res   = sum[7:0];
            upd_z = 1'b1;
            upd_c = 1'b1;
        end else if (is_and_lit || is_and_reg) begin    // RULE_02 RULE_05
            res   = acc & opnd;
            upd_z = 1'b1;
        end else if (is_xor_lit || is_xor_reg) begin    // RULE_14 RULE_15
            res   = acc ^ opnd;
            upd_z = 1'b1;
        end else if (is_inc) begin                      // RULE_08
            res   = reg_rdata + AIE_ONE;
            upd_z = 1'b1;
        end else if (is_decsz) begin                    // RULE_06
            res   = reg_rdata - AIE_ONE;
        end else if (is_swap) begin                     // RULE_12
            res   = {reg_rdata[3:0], reg_rdata[7:4]};
        end else if (is_ret_lit) begin                  // RULE_10
            res   = lit;
        end else if (!(is_branch || is_ret || is_reti || is_dir)) begin
            known = 1'b0;                               // RULE_17
        end
    end

    assign to_reg = is_reg && dbit && known &&
                    !(is_ret || is_reti || is_dir);     // RULE_04
    assign reg_we    = exec && to_reg;
    assign reg_wdata = res;
    assign unhandled = exec && !known;                  // RULE_17
    assign dir_we    = exec && is_dir;                  // RULE_13
    assign dir_sel   = instr[2:0];
    assign dir_wdata = acc;

    // ------------------------------------------------------------
    // accumulator and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc <= 8'h00;
        end else if (exec && known && !to_reg &&
                     !(is_branch || is_ret || is_reti || is_dir)) begin
            acc <= res;                                 // RULE_04
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zero_flag        <= 1'b0;
            carry_flag       <= 1'b0;
            digit_carry_flag <= 1'b0;
        end else if (exec) begin
            if (upd_z) begin
                zero_flag <= res == 8'h00;              // RULE_16
            end
            if (upd_c) begin
                carry_flag       <= sum[8];             // RULE_16
                digit_carry_flag <= low_sum[4];
            end
        end
    end

    // set by interrupt return wins over an external clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            global_interrupt_enable <= 1'b0;
        end else if (exec && is_reti) begin
            global_interrupt_enable <= 1'b1;            // RULE_09
        end else if (int_enable_clear) begin
            global_interrupt_enable <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // program counter and flush
    // ------------------------------------------------------------
    logic pops;
    logic redirect;
    assign pops = exec && (is_ret || is_reti || is_ret_lit);
    assign sif.pop  = pops;                             // RULE_09 RULE_11
    assign sif.push = call_push;
    assign sif.push_addr = call_addr;
    assign redirect = exec && (is_branch || pops ||
                      (is_decsz && res == 8'h00));      // RULE_06

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc <= '0;
        end else if (exec && is_branch) begin
            pc <= {program_counter_high_latch[4:3], instr[10:0]}; // RULE_07
        end else if (pops) begin
            pc <= sif.stack_top;                        // RULE_10 RULE_11
        end else if (instr_valid) begin
            pc <= pc + 1'b1;
        end
    end

    // the fetched word after a redirect is dropped as a no-op cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= AIE_RUN;
        end else begin
            case (state_r)
                AIE_RUN: begin
                    if (redirect) begin
                        state_r <= AIE_FLUSH;           // RULE_06 RULE_07
                    end
                end
                AIE_FLUSH: begin
                    if (instr_valid) begin
                        state_r <= AIE_RUN;
                    end
                end
                default: begin
                    state_r <= AIE_RUN;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- core/aie_pkg.sv
// constants and types shared by the instruction executor
// Contract
// (RULE_01) add literal to accumulator, all three flags
// (RULE_02) and literal into accumulator, zero flag only
// (RULE_03) add accumulator and register, all three flags
// (RULE_04) dest bit picks accumulator or register, 0..127
// (RULE_05) and accumulator with register, zero flag only
// (RULE_06) decrement register, skip next when zero, no flags
// (RULE_07) branch loads pc low, latch bits give high
// (RULE_08) increment register, zero flag only
// (RULE_09) interrupt return pops stack, sets interrupt enable
// (RULE_10) literal return loads accumulator and pops stack
// (RULE_11) subroutine return pops stack into pc
// (RULE_12) swap register nibbles, no flags
// (RULE_13) direction load copies accumulator, operand 5..7
// (RULE_14) xor literal into accumulator, zero flag only
// (RULE_15) xor accumulator with register, zero flag only
// (RULE_16) zero, carry bit7, digit carry bit3 semantics
// (RULE_17) other encodings pass on, state unchanged
package aie_pkg;
    localparam int   AIE_IW      = 14;
    localparam int   AIE_DW      = 8;
    localparam int   AIE_AW      = 7;
    localparam int   AIE_PCW     = 13;
    localparam int   AIE_DEPTH   = 8;
    localparam logic [13:0] AIE_RET_W  = 14'h0008;
    localparam logic [13:0] AIE_RETI_W = 14'h0009;
    localparam logic [10:0] AIE_DIR_HI = 11'h00c;
    localparam logic [2:0]  AIE_DIR_LO = 3'h5;
    localparam logic [2:0]  AIE_DIR_HI_SEL = 3'h7;
    localparam logic [7:0]  AIE_ONE   = 8'h01;
    localparam logic [3:0]  OP_AND_REG_C = 4'h5;
    localparam logic [3:0]  OP_XOR_REG_C = 4'h6;
    localparam logic [3:0]  OP_ADD_REG_C = 4'h7;
    localparam logic [3:0]  OP_INC_C   = 4'ha;
    localparam logic [3:0]  OP_DECSZ_C = 4'hb;
    localparam logic [3:0]  OP_SWAP_C  = 4'he;
    localparam logic [3:0]  LIT_AND_C  = 4'h9;
    localparam logic [3:0]  LIT_XOR_C  = 4'ha;
    typedef enum {
        AIE_RUN,
        AIE_FLUSH
    } aie_state_t;
endpackage

//--- core/aie_stack.sv
// return address stack, top word held in a register
`timescale 1ns/1ps
`default_nettype none
module aie_stack #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // core side
    aie_stack_if.store st
);
    import aie_pkg::*;
    // the pointer wraps by its width, so the depth must be a power of two
    if (DEPTH < 2 || DEPTH > 64 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("aie_stack: bad depth");
    end
    localparam int PW = $clog2(DEPTH);
    logic [12:0]   mem [DEPTH];
    logic [PW-1:0] ptr_r;
    logic [12:0]   top_r;
    // the stack wraps silently on overflow, as small cores do
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptr_r <= '0;
        end else if (st.push) begin
            ptr_r <= ptr_r + 1'b1;
        end else if (st.pop) begin
            ptr_r <= ptr_r - 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (st.push) begin
            mem[ptr_r] <= top_r;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            top_r <= '0;
        end else if (st.push) begin
            top_r <= st.push_addr;
        end else if (st.pop) begin
            top_r <= mem[ptr_r - 1'b1];
        end
    end
    assign st.stack_top = top_r;
endmodule
`default_nettype wire

//--- core/aie_stack_if.sv
// push/pop carrier between core and return stack
`timescale 1ns/1ps
`default_nettype none
interface aie_stack_if;
    logic        push;
    logic        pop;
    logic [12:0] push_addr;
    logic [12:0] stack_top;
    modport core  (output push, output pop, output push_addr,
                   input stack_top);
    modport store (input push, input pop, input push_addr,
                   output stack_top);
endinterface
`default_nettype wire

//--- dv/aie_core_tb.sv
// self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h expected %h", $time, g, e); end end
module aie_core_tb;
    logic        clk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
    logic        int_enable_clear = 1'b0, call_push = 1'b0;
    logic        reg_we, dir_we, zf, cf, dcf, int_en, unh;
    logic [13:0] instr = 14'h0;
    logic [12:0] call_addr = 13'h0, pc;
    logic [4:0]  latch = 5'h0;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_rdata, reg_wdata, dir_wdata, acc;
    logic [2:0]  dir_sel;
    int          n_mismatch = 0, n_compared = 0;
    always #20 clk = ~clk;
    aie_core dut_u (.clk(clk), .reset(reset), .instr(instr),
        .instr_valid(instr_valid), .pc(pc), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .reg_we(reg_we), .reg_wdata(reg_wdata),
        .program_counter_high_latch(latch), .call_push(call_push),
        .call_addr(call_addr), .dir_we(dir_we), .dir_sel(dir_sel),
        .dir_wdata(dir_wdata), .acc(acc), .zero_flag(zf), .carry_flag(cf),
        .digit_carry_flag(dcf), .global_interrupt_enable(int_en),
        .int_enable_clear(int_enable_clear), .unhandled(unh));
    aie_regfile rf_u (.clk(clk), .reg_addr(reg_addr), .reg_we(reg_we),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // one executed word, then an idle cycle
    task automatic op(input logic [13:0] w);
        @(negedge clk);
        instr = w;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask
    task automatic push(input logic [12:0] a);
        @(negedge clk);
        call_push = 1'b1;
        call_addr = a;
        @(negedge clk);
        call_push = 1'b0;
    endtask
    task automatic t_literal;
        op(14'h3e10);
        op(14'h3e15);
        `CHK(acc, 8'h25)
        op(14'h3edb);
        `CHK({acc, cf, dcf, zf}, {8'h00, 3'b111})
        op(14'h3aa3);
        op(14'h395f);
        `CHK({acc, cf, zf}, {8'h03, 2'b10})
        op(14'h3a03);
        `CHK({acc, zf}, {8'h00, 1'b1})
        $display("literal test done");
    endtask
    task automatic t_register;
        rf_u.mem[7'h22] = 8'hc2;
        rf_u.mem[7'h7f] = 8'hff;
        op(14'h3a17);
        op(14'h0722);
        `CHK({acc, rf_u.mem[7'h22], cf, dcf}, {16'hd9c2, 2'b00})
        op(14'h05a2);
        `CHK(rf_u.mem[7'h22], 8'hc0)
        op(14'h06a2);
        `CHK(rf_u.mem[7'h22], 8'h19)
        op(14'h0aff);
        `CHK({rf_u.mem[7'h7f], zf}, {8'h00, 1'b1})
        op(14'h0e22);
        `CHK({acc, zf}, {8'h91, 1'b1})
        $display("register test done");
    endtask
    task automatic t_skip;
        rf_u.mem[7'h10] = 8'h02;
        op(14'h0b90);
        op(14'h3a01);
        `CHK({acc, rf_u.mem[7'h10]}, 16'h9001)
        op(14'h0b90);
        op(14'h3a01);
        `CHK({acc, rf_u.mem[7'h10], zf}, {16'h9000, 1'b0})
        latch = 5'h18;
        op(14'h2923);
        `CHK(pc, 13'h1923)
        op(14'h3a01);
        `CHK(acc, 8'h90)
        $display("skip and branch test done");
    endtask
    task automatic t_return;
        push(13'h0111);
        push(13'h0222);
        @(negedge clk) int_enable_clear = 1'b1;
        @(negedge clk) int_enable_clear = 1'b0;
        op(14'h0009);
        `CHK({pc, int_en}, {13'h0222, 1'b1})
        op(14'h3a01);
        @(negedge clk) int_enable_clear = 1'b1;
        @(negedge clk) int_enable_clear = 1'b0;
        `CHK(int_en, 1'b0)
        // return and clear in one cycle: the set must win
        push(13'h0444);
        @(negedge clk);
        instr = 14'h0009;
        instr_valid = 1'b1;
        int_enable_clear = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        int_enable_clear = 1'b0;
        `CHK({pc, int_en}, {13'h0444, 1'b1})
        op(14'h3a01);
        op(14'h345a);
        `CHK({pc, acc}, {13'h0111, 8'h5a})
        op(14'h3a01);
        push(13'h0333);
        op(14'h0008);
        `CHK(pc, 13'h0333)
        op(14'h3a01);
        `CHK(acc, 8'h5a)
        $display("return test done");
    endtask
    task automatic t_direction;
        @(negedge clk);
        instr = 14'h0066;
        instr_valid = 1'b1;
        #1 `CHK({dir_we, dir_sel, dir_wdata}, {4'he, 8'h5a})
        @(negedge clk);
        instr = 14'h0064;
        #1 `CHK({dir_we, unh}, 2'b01)
        @(negedge clk);
        instr_valid = 1'b0;
        `CHK(acc, 8'h5a)
        $display("direction test done");
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_literal;
        t_register;
        t_skip;
        t_return;
        t_direction;
        wrap_up;
    end
    // all tests take well under 200 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule
`default_nettype wire

//--- dv/aie_props.sv
// concurrent checks on the instruction executor ports
`timescale 1ns/1ps
`default_nettype none
module aie_props #(
    parameter int STACK_DEPTH = 8
) (
    // clock, reset, program memory, register file
    input wire logic        clk, reset, instr_valid, reg_we,
    input wire logic [13:0] instr,
    input wire logic [12:0] pc, call_addr,
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_rdata, reg_wdata, dir_wdata, acc,
    // latch, link, direction, state
    input wire logic [4:0]  program_counter_high_latch,
    input wire logic [2:0]  dir_sel,
    input wire logic        call_push, dir_we, zero_flag, carry_flag,
    input wire logic        digit_carry_flag, global_interrupt_enable,
    input wire logic        int_enable_clear, unhandled
);
    logic flush_r;
    wire  exe = instr_valid && !flush_r;
    // mirrors the discard cycle so the word after a jump is not judged
    always_ff @(posedge clk or posedge reset)
        if (reset) flush_r <= 1'b0;
        else if (instr_valid) flush_r <= exe && (instr[13:11] == 3'h5 ||
            instr[13:10] == 4'hd || instr[13:1] == 13'h0004 ||
            (instr[13:8] == 6'h0b && reg_rdata == 8'h01));
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_add_lit; exe && instr[13:9] == 5'h1f |=>
        acc == $past(acc) + $past(instr[7:0]); endproperty
    a_add_lit: assert property (p_add_lit)
        else $error("add literal bad");
    property p_and_lit; exe && instr[13:8] == 6'h39 |=> acc == ($past(acc)
        & $past(instr[7:0])) && $stable(carry_flag); endproperty
    a_and_lit: assert property (p_and_lit)
        else $error("and literal bad");
    property p_zflag; exe && instr[13:8] == 6'h3a |=>
        zero_flag == (acc == 8'h00); endproperty
    a_zflag: assert property (p_zflag)
        else $error("zero flag bad");
    property p_branch; exe && instr[13:11] == 3'h5 |=>
        pc == {$past(program_counter_high_latch[4:3]), $past(instr[10:0])};
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch target bad");
    property p_dest; exe && instr[13:12] == 2'h0 && instr[11:8] inside
        {4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'he} |->
        reg_we == instr[7] && reg_addr == instr[6:0]; endproperty
    a_dest: assert property (p_dest) else $error("destination bad");
    property p_swap; exe && instr[13:8] == 6'h0e |->
        reg_wdata == {reg_rdata[3:0], reg_rdata[7:4]}; endproperty
    a_swap: assert property (p_swap) else $error("swap bad");
    property p_dir; exe && instr[13:3] == 11'h00c && instr[2:0] >= 3'h5 |->
        dir_we && dir_sel == instr[2:0] && dir_wdata == acc; endproperty
    a_dir: assert property (p_dir) else $error("direction load bad");
    property p_reti; exe && instr == 14'h0009 |=> global_interrupt_enable;
    endproperty
    a_reti: assert property (p_reti) else $error("enable not set");
    property p_flush; instr_valid && flush_r |-> !reg_we && !dir_we ##1
        $stable(acc) && $stable(zero_flag); endproperty
    a_flush: assert property (p_flush) else $error("discard bad");
    property p_inc; exe && instr[13:8] == 6'h0a |->
        reg_wdata == reg_rdata + 8'h01 ##1
        zero_flag == ($past(reg_rdata) == 8'hff); endproperty
    a_inc: assert property (p_inc) else $error("increment bad");
endmodule
bind aie_core aie_props #(.STACK_DEPTH(STACK_DEPTH)) props_u (.*);
`default_nettype wire

//--- dv/aie_regfile.sv
// data register file model on the far side of the executor
`timescale 1ns/1ps
`default_nettype none
module aie_regfile (
    input  wire logic       clk,
    input  wire logic [6:0] reg_addr,
    input  wire logic       reg_we,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata
);
    logic [7:0] mem [128];
    assign reg_rdata = mem[reg_addr];
    // plain always so the bench may preload cells directly
    always @(posedge clk)
        if (reg_we) mem[reg_addr] <= reg_wdata;
endmodule
`default_nettype wire
